// File: hw/txcfg_regs.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
module txcfg_regs
    import txcfg_pkg::*;
#(
    parameter int SAMPLE_W = 10,
    parameter int HALF_CYC = OUT_HALF_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Power-down pin from the board.
    input wire logic tx_power_down_pin,
    // Transmit data interface.
    output logic output_clock,
    input wire logic [SAMPLE_W-1:0] tx_data,
    output logic [SAMPLE_W-1:0] tx_sample,
    output logic tx_sample_valid,
    // Receive data path.
    input wire logic [SAMPLE_W-1:0] rx_data_in,
    output logic [SAMPLE_W-1:0] rx_data_out,
    // Gain amplifier control.
    output logic [7:0] tx_gain_amplifier,
    output logic [7:0] gain_atten_tenths,
    output logic gain_settled,
    // Interpolation control.
    output logic [2:0] interp_factor,
    output logic interp_stage1_en,
    output logic interp_stage2_en
);

    // A one-bit word has no sign bit to flip, and the divider needs a nonzero count.
    // The divider counter is 16 bits wide, which caps the half period.
    if (SAMPLE_W < 2 || HALF_CYC < 1 || HALF_CYC > 65536) begin : g_bad_param
        $error("txcfg_regs: SAMPLE_W must be at least 2 and HALF_CYC 1 to 65536");
    end

    localparam logic [SAMPLE_W-1:0] SIGN_FLIP = {1'b1, {(SAMPLE_W-1){1'b0}}};

    logic [7:0] gain_wr_reg;
    logic [7:0] upd_reg;
    logic [7:0] fmt_reg;
    logic [7:0] pending_reg;
    logic pending_valid_reg;
    logic [7:0] target_reg;
    logic [7:0] current_reg;
    logic [7:0] current_next;
    logic [7:0] atten_reg;
    txcfg_gstate_e gstate_reg;
    logic [15:0] ramp_cnt_reg;
    logic ramp_tick;
    logic pd_s1_reg, pd_s2_reg, pd_s3_reg, pd_level_reg;
    logic wake;
    logic gain_wr;
    logic sync_on, quick_on;
    logic [15:0] oclk_cnt_reg;
    logic oclk_reg;
    logic rise_tick, fall_tick, cap_tick;
    logic [7:0] rdata_reg;
    logic [7:0] stat_word;
    logic [15:0] atten_calc;

    assign gain_wr = reg_wr && (reg_addr == OFS_GAIN);
    assign sync_on = upd_reg[BIT_SYNC_WAKE];
    assign quick_on = upd_reg[BIT_QUICK];

    // Software-visible registers; reserved bits are masked so they always read zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_wr_reg <= GAIN_RST;
            upd_reg <= UPD_RST;
            fmt_reg <= FMT_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_GAIN: gain_wr_reg <= reg_wdata;
                OFS_UPD: upd_reg <= reg_wdata & UPD_MASK;
                OFS_FMT: fmt_reg <= reg_wdata & FMT_MASK;
                default: ;
            endcase
        end
    end

    // Read data is registered and stands only in the cycle after the strobe.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_GAIN: rdata_reg <= gain_wr_reg;
                OFS_UPD: rdata_reg <= upd_reg;
                OFS_FMT: rdata_reg <= fmt_reg;
                OFS_GAIN_NOW: rdata_reg <= current_reg;
                OFS_STAT: rdata_reg <= stat_word;
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign reg_rdata = rdata_reg;

    // Status word; unused bits read as zero.
    always_comb begin
        stat_word = 8'h00;
        stat_word[BIT_STAT_RAMP] = (gstate_reg == GST_RAMPING);
        stat_word[BIT_STAT_PEND] = pending_valid_reg;
    end

    // The pin is asynchronous, so it passes three stages and counts once two agree.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pd_s1_reg <= 1'b1;
            pd_s2_reg <= 1'b1;
            pd_s3_reg <= 1'b1;
            pd_level_reg <= 1'b1;
        end else begin
            pd_s1_reg <= tx_power_down_pin;
            pd_s2_reg <= pd_s1_reg;
            pd_s3_reg <= pd_s2_reg;
            if (pd_s2_reg == pd_s3_reg) begin
                pd_level_reg <= pd_s3_reg;
            end
        end
    end
    // Wake-up is the filtered release of power-down.
    assign wake = pd_level_reg && (pd_s2_reg == pd_s3_reg) && !pd_s3_reg;

    // Held code for wake-up sync; a write in the wake cycle stays held for the next wake.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending_reg <= GAIN_RST;
            pending_valid_reg <= 1'b0;
        end else if (gain_wr && sync_on) begin
            pending_reg <= reg_wdata;
            pending_valid_reg <= 1'b1;
        end else if (wake) begin
            pending_valid_reg <= 1'b0;
        end
    end

    // Target gain: at once without sync, else at wake-up; a direct write beats the wake.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            target_reg <= GAIN_RST;
        end else if (gain_wr && !sync_on) begin
            target_reg <= reg_wdata;
        end else if (wake && pending_valid_reg) begin
            target_reg <= pending_reg;
        end
    end

    // Ramp tick divider sets the smooth slew rate.
    always_ff @(posedge clk) begin
        if (!rst_n || gstate_reg == GST_SETTLED) begin
            ramp_cnt_reg <= 16'h0000;
        end else if (ramp_tick) begin
            ramp_cnt_reg <= 16'h0000;
        end else begin
            ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
        end
    end
    assign ramp_tick = (ramp_cnt_reg == 16'(RAMP_STEP_CYC - 1));

    // Next applied code: a jump in quick mode, one step per tick otherwise.
    always_comb begin
        current_next = current_reg;
        if (gstate_reg == GST_RAMPING) begin
            if (quick_on) begin
                current_next = target_reg;
            end else if (ramp_tick && current_reg < target_reg) begin
                current_next = current_reg + 8'h01;
            end else if (ramp_tick && current_reg > target_reg) begin
                current_next = current_reg - 8'h01;
            end
        end
    end

    // Slew state; quick mode trades spurs for settling two cycles after the target changes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gstate_reg <= GST_SETTLED;
            current_reg <= GAIN_RST;
        end else begin
            current_reg <= current_next;
            case (gstate_reg)
                GST_SETTLED: begin
                    if (target_reg != current_reg) begin
                        gstate_reg <= GST_RAMPING;
                    end
                end
                GST_RAMPING: begin
                    if (current_next == target_reg) begin
                        gstate_reg <= GST_SETTLED;
                    end
                end
                default: gstate_reg <= GST_SETTLED;
            endcase
        end
    end

    // Map code to attenuation: 00 gives 200 tenths, FF gives none, rounded to nearest.
    assign atten_calc = ((16'(GAIN_MAX_CODE - current_reg) * ATTEN_SPAN_TENTHS)
                         + ATTEN_ROUND) / 16'h00FF;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            atten_reg <= 8'h00;
        end else begin
            atten_reg <= atten_calc[7:0];
        end
    end
    assign tx_gain_amplifier = current_reg;
    assign gain_atten_tenths = atten_reg;
    assign gain_settled = (gstate_reg == GST_SETTLED);

    // Output clock from a divider; edge pulses drive the capture.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oclk_cnt_reg <= 16'h0000;
            oclk_reg <= 1'b0;
        end else if (oclk_cnt_reg == 16'(HALF_CYC - 1)) begin
            oclk_cnt_reg <= 16'h0000;
            oclk_reg <= !oclk_reg;
        end else begin
            oclk_cnt_reg <= oclk_cnt_reg + 16'h0001;
        end
    end
    assign rise_tick = (oclk_cnt_reg == 16'(HALF_CYC - 1)) && !oclk_reg;
    assign fall_tick = (oclk_cnt_reg == 16'(HALF_CYC - 1)) && oclk_reg;
    assign output_clock = oclk_reg;
    // The source must hold data stable at the chosen edge; nothing here retimes it.
    assign cap_tick = fmt_reg[BIT_TX_INV] ? fall_tick : rise_tick;

    // Captured words are converted to straight binary for the converter path.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_sample <= '0;
            tx_sample_valid <= 1'b0;
        end else begin
            tx_sample_valid <= cap_tick;
            if (cap_tick) begin
                tx_sample <= fmt_reg[BIT_TX_2C] ? (tx_data ^ SIGN_FLIP) : tx_data;
            end
        end
    end

    // Converter words are straight binary; flip the sign bit for two's complement.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_data_out <= '0;
        end else begin
            rx_data_out <= fmt_reg[BIT_RX_2C] ? (rx_data_in ^ SIGN_FLIP) : rx_data_in;
        end
    end

    // Interpolation decode; the reserved code falls back to bypass.
    always_comb begin
        case (txcfg_interp_e'({fmt_reg[BIT_INTERP_MSB], fmt_reg[BIT_INTERP_LSB]}))
            INTERP_X2: begin
                interp_factor = FACTOR_X2;
                interp_stage1_en = 1'b1;
                interp_stage2_en = 1'b0;
            end
            INTERP_X4: begin
                interp_factor = FACTOR_X4;
                interp_stage1_en = 1'b1;
                interp_stage2_en = 1'b1;
            end
            default: begin
                interp_factor = FACTOR_X1;
                interp_stage1_en = 1'b0;
                interp_stage2_en = 1'b0;
            end
        endcase
    end

    default clocking ast_cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Gain scale endpoints appear on the attenuation output one cycle later.
    AST_MIN_GAIN: assert property ((current_reg == GAIN_MIN_CODE) |=>
        (atten_reg == ATTEN_SPAN_TENTHS[7:0]))
        else $error("code 00 did not give 20 dB attenuation");
    AST_MAX_GAIN: assert property ((current_reg == GAIN_MAX_CODE) |=>
        (atten_reg == 8'h00))
        else $error("code FF did not give zero attenuation");
    AST_IMMEDIATE: assert property ((gain_wr && !sync_on) |=>
        (target_reg == $past(reg_wdata)))
        else $error("gain write without sync not applied at once");
    AST_HOLD_UNTIL_WAKE: assert property ((gain_wr && sync_on && !wake) |=>
        (target_reg == $past(target_reg)) && pending_valid_reg)
        else $error("synced gain write changed the target early");
    AST_WAKE_APPLY: assert property ((wake && pending_valid_reg && !gain_wr) |=>
        (target_reg == $past(pending_reg)))
        else $error("held gain not applied at wake-up");
    AST_QUICK: assert property ((quick_on && target_reg != current_reg)
        |-> ##[1:3] (current_reg == target_reg) || (target_reg != $past(target_reg)))
        else $error("quick mode gain did not settle within three cycles");
    AST_SMOOTH: assert property (!quick_on |=>
        (current_reg == $past(current_reg)) || (current_reg == $past(current_reg) + 8'h01)
        || (current_reg == $past(current_reg) - 8'h01))
        else $error("smooth mode gain moved more than one step");
    AST_TX_FORMAT: assert property (cap_tick |=>
        (tx_sample[SAMPLE_W-1] == ($past(tx_data[SAMPLE_W-1]) ^ $past(fmt_reg[BIT_TX_2C]))))
        else $error("transmit word format conversion wrong");
    AST_RX_FORMAT: assert property (1'b1 |=>
        (rx_data_out[SAMPLE_W-1] == ($past(rx_data_in[SAMPLE_W-1]) ^ $past(fmt_reg[BIT_RX_2C]))))
        else $error("receive word format conversion wrong");
    AST_CAPTURE_EDGE: assert property (tx_sample_valid |->
        (output_clock == !$past(fmt_reg[BIT_TX_INV])))
        else $error("transmit data captured on the wrong output clock edge");
    AST_INTERP: assert property ((fmt_reg[1:0] == 2'b00 || fmt_reg[1:0] == 2'b11) |->
        (interp_factor == FACTOR_X1) && !interp_stage1_en && !interp_stage2_en)
        else $error("bypass or reserved selector did not bypass");
    AST_INTERP_X2: assert property ((fmt_reg[1:0] == 2'b01) |->
        (interp_factor == FACTOR_X2) && interp_stage1_en && !interp_stage2_en)
        else $error("selector 01 did not give two times interpolation");
    AST_INTERP_X4: assert property ((fmt_reg[1:0] == 2'b10) |->
        (interp_factor == FACTOR_X4) && interp_stage2_en)
        else $error("selector 10 did not give four times interpolation");
    AST_RESET_GAIN: assert property ($rose(rst_n) |->
        (gain_wr_reg == GAIN_RST) && (current_reg == GAIN_RST))
        else $error("gain code did not reset to all ones");

endmodule

// File: pkg/txcfg_pkg.sv
package txcfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // Register offsets as seen on the register port.
    localparam logic [7:0] OFS_GAIN = 8'h0B;
    localparam logic [7:0] OFS_UPD = 8'h0C;
    localparam logic [7:0] OFS_FMT = 8'h0D;
    localparam logic [7:0] OFS_GAIN_NOW = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h11;
    // Field positions.
    localparam int BIT_SYNC_WAKE = 6;
    localparam int BIT_QUICK = 4;
    localparam int BIT_TX_2C = 7;
    localparam int BIT_RX_2C = 6;
    localparam int BIT_TX_INV = 5;
    localparam int BIT_INTERP_MSB = 1;
    localparam int BIT_INTERP_LSB = 0;
    localparam int BIT_STAT_RAMP = 0;
    localparam int BIT_STAT_PEND = 1;
    // Writable bits; all others read as zero.
    localparam logic [7:0] UPD_MASK = 8'h50;
    localparam logic [7:0] FMT_MASK = 8'hE3;
    // Reset values.
    localparam logic [7:0] GAIN_RST = 8'hFF;
    localparam logic [7:0] UPD_RST = 8'h00;
    localparam logic [7:0] FMT_RST = 8'h00;
    // Gain scale: code 00 is -20.0 dB, code FF is 0 dB, attenuation in tenths of a dB.
    localparam logic [7:0] GAIN_MIN_CODE = 8'h00;
    localparam logic [7:0] GAIN_MAX_CODE = 8'hFF;
    localparam logic [15:0] ATTEN_SPAN_TENTHS = 16'h00C8;
    localparam logic [15:0] ATTEN_ROUND = 16'h007F;
    // Interpolation selector codes.
    typedef enum logic [1:0] {
        INTERP_BYPASS = 2'b00,
        INTERP_X2 = 2'b01,
        INTERP_X4 = 2'b10,
        INTERP_RSVD = 2'b11
    } txcfg_interp_e;
    localparam logic [2:0] FACTOR_X1 = 3'h1;
    localparam logic [2:0] FACTOR_X2 = 3'h2;
    localparam logic [2:0] FACTOR_X4 = 3'h4;
    // Gain slew states.
    typedef enum logic [0:0] {
        GST_SETTLED = 1'b0,
        GST_RAMPING = 1'b1
    } txcfg_gstate_e;
    // Timing: clock period and smooth ramp step time.
    localparam int CLK_PERIOD_NS = 100;
    localparam int RAMP_STEP_NS = 1000;
    localparam int RAMP_STEP_CYC_RAW = RAMP_STEP_NS / CLK_PERIOD_NS;
    localparam int RAMP_STEP_CYC = (RAMP_STEP_CYC_RAW < 1) ? 1 : RAMP_STEP_CYC_RAW;
    localparam int OUT_HALF_CYC = 2;
endpackage

// File: tb/txcfg_bb_model.sv
`timescale 1ns/10ps
// Baseband source that steps to a new transmit word once per output clock period.
module txcfg_bb_model #(
    parameter int SAMPLE_W = 10
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Output clock from the block and the chosen capture edge.
    input wire logic output_clock,
    input wire logic fall_sel,
    // Transmit word towards the block.
    output logic [SAMPLE_W-1:0] tx_data
);
    logic oclk_reg;

    // The word changes just after the unused edge, so it is stable at the capture edge.
    always_ff @(posedge clk) begin
        oclk_reg <= output_clock;
        if (!rst_n) begin
            tx_data <= '0;
        end else if (output_clock != oclk_reg && output_clock == fall_sel) begin
            tx_data <= tx_data + SAMPLE_W'(10'h1A7);
        end
    end
endmodule

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import txcfg_pkg::*;
    localparam int SW = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic tx_power_down_pin = 1'b0;
    logic output_clock;
    logic fall_sel = 1'b0;
    logic [SW-1:0] tx_data;
    logic [SW-1:0] tx_sample;
    logic tx_sample_valid;
    logic [SW-1:0] rx_data_in = 10'h000;
    logic [SW-1:0] rx_data_out;
    logic [7:0] tx_gain_amplifier;
    logic [7:0] gain_atten_tenths;
    logic gain_settled;
    logic [2:0] interp_factor;
    logic interp_stage1_en;
    logic interp_stage2_en;
    int error_cnt = 0;
    int checks = 0;

    // Device under test and the baseband source feeding it.
    txcfg_regs #(.SAMPLE_W(SW), .HALF_CYC(2)) txcfg_regs_inst (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_power_down_pin(tx_power_down_pin),
        .output_clock(output_clock), .tx_data(tx_data), .tx_sample(tx_sample),
        .tx_sample_valid(tx_sample_valid), .rx_data_in(rx_data_in), .rx_data_out(rx_data_out),
        .tx_gain_amplifier(tx_gain_amplifier), .gain_atten_tenths(gain_atten_tenths),
        .gain_settled(gain_settled), .interp_factor(interp_factor),
        .interp_stage1_en(interp_stage1_en), .interp_stage2_en(interp_stage2_en));
    txcfg_bb_model #(.SAMPLE_W(SW)) txcfg_bb_model_inst (.clk(clk), .rst_n(rst_n),
        .output_clock(output_clock), .fall_sel(fall_sel), .tx_data(tx_data));

    // Clock of 100 ns period.
    always #50 clk = ~clk;

    // Comparison helpers, one for bytes and one for sample words.
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [SW-1:0] got, input logic [SW-1:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register port cycles; a read returns the data of the cycle after the strobe.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Waits a bounded time for the applied gain to settle on a code.
    task automatic wait_gain(input logic [7:0] code, input int lim);
        int n;
        n = 0;
        #1;
        while (!(tx_gain_amplifier === code && gain_settled === 1'b1) && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_byte(tx_gain_amplifier, code);
    endtask

    task automatic test_reset();
        logic [7:0] d;
        rd_reg(OFS_GAIN, d);
        chk_byte(d, 8'hFF);
        rd_reg(OFS_UPD, d);
        chk_byte(d, 8'h00);
        rd_reg(OFS_FMT, d);
        chk_byte(d, 8'h00);
        wr_reg(8'h20, 8'hAA);
        rd_reg(8'h20, d);
        chk_byte(d, 8'h00);
        chk_byte(tx_gain_amplifier, 8'hFF);
        $display("test_reset done");
    endtask

    task automatic test_quick();
        logic [7:0] d;
        wr_reg(OFS_UPD, 8'hFF);
        rd_reg(OFS_UPD, d);
        chk_byte(d, 8'h50);
        wr_reg(OFS_UPD, 8'h10);
        wr_reg(OFS_GAIN, 8'h00);
        wait_gain(8'h00, 4);
        repeat (2) @(posedge clk);
        #1;
        chk_byte(gain_atten_tenths, 8'hC8);
        wr_reg(OFS_GAIN, 8'hFF);
        wait_gain(8'hFF, 4);
        repeat (2) @(posedge clk);
        #1;
        chk_byte(gain_atten_tenths, 8'h00);
        $display("test_quick done");
    endtask

    task automatic test_smooth();
        logic [7:0] d;
        wr_reg(OFS_UPD, 8'h00);
        wr_reg(OFS_GAIN, 8'hFC);
        repeat (5) @(posedge clk);
        #1;
        chk_byte(tx_gain_amplifier, 8'hFF);
        chk_byte({7'h00, gain_settled}, 8'h00);
        rd_reg(OFS_STAT, d);
        chk_byte(d, 8'h01);
        wait_gain(8'hFC, 45);
        $display("test_smooth done");
    endtask

    task automatic test_sync();
        logic [7:0] d;
        @(posedge clk);
        tx_power_down_pin <= 1'b1;
        wr_reg(OFS_UPD, 8'h50);
        wr_reg(OFS_GAIN, 8'h80);
        repeat (20) @(posedge clk);
        #1;
        chk_byte(tx_gain_amplifier, 8'hFC);
        rd_reg(OFS_STAT, d);
        chk_byte(d, 8'h02);
        @(posedge clk);
        tx_power_down_pin <= 1'b0;
        wait_gain(8'h80, 10);
        rd_reg(OFS_GAIN_NOW, d);
        chk_byte(d, 8'h80);
        repeat (2) @(posedge clk);
        #1;
        chk_byte(gain_atten_tenths, 8'h64);
        wr_reg(OFS_UPD, 8'h10);
        wr_reg(OFS_GAIN, 8'h21);
        wait_gain(8'h21, 4);
        $display("test_sync done");
    endtask

    task automatic test_format();
        logic [7:0] cfg [4] = '{8'h00, 8'h80, 8'h20, 8'hA0};
        logic [SW-1:0] exp;
        int n;
        foreach (cfg[i]) begin
            wr_reg(OFS_FMT, cfg[i]);
            fall_sel <= cfg[i][5];
            repeat (12) @(posedge clk);
            #1;
            n = 0;
            while (tx_sample_valid !== 1'b1 && n < 8) begin
                @(posedge clk);
                #1;
                n++;
            end
            exp = cfg[i][7] ? {~tx_data[SW-1], tx_data[SW-2:0]} : tx_data;
            chk_word(tx_sample, exp);
            chk_byte({7'h00, output_clock}, {7'h00, ~cfg[i][5]});
        end
        @(posedge clk);
        rx_data_in <= 10'h2A5;
        wr_reg(OFS_FMT, 8'h40);
        repeat (2) @(posedge clk);
        #1;
        chk_word(rx_data_out, 10'h0A5);
        wr_reg(OFS_FMT, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk_word(rx_data_out, 10'h2A5);
        $display("test_format done");
    endtask

    task automatic test_interp();
        logic [7:0] d;
        logic [2:0] fct [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
        logic [1:0] stg [4] = '{2'b00, 2'b10, 2'b11, 2'b00};
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFS_FMT, 8'h1C | 8'(i));
            rd_reg(OFS_FMT, d);
            chk_byte(d, 8'(i));
            chk_byte({5'h00, interp_factor}, {5'h00, fct[i]});
            chk_byte({6'h00, interp_stage1_en, interp_stage2_en}, {6'h00, stg[i]});
        end
        $display("test_interp done");
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence after a reset of five cycles.
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_quick();
        test_smooth();
        test_sync();
        test_format();
        test_interp();
        complete_run();
    end

    // Watchdog; the tests need well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule
